// ===== logic/hco_pkg.sv
// Holds register offsets, field positions, reset values and codes of the cursor overlay.
// Assumes a single clock domain and the documented register port offsets.
package hco_pkg;
    localparam int REG_COUNT = 10;
    localparam logic [7:0] REG_OFS [REG_COUNT] = '{8'h84, 8'h88, 8'h8C, 8'h90, 8'h94, 8'h98, 8'h9C, 8'hA0,
        8'hA4, 8'hA8};
    localparam logic [15:0] REG_MASK [REG_COUNT] = '{16'hFFFF, 16'h3F3F, 16'h07FF, 16'h07FF, 16'hFFFF,
        16'hC0FF, 16'hFFFF, 16'h80FF, 16'hFFFF, 16'h80FF};
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam int IDX_PATTERN_BASE = 0;
    localparam int IDX_ORIGIN = 1;
    localparam int IDX_SCREEN_X = 2;
    localparam int IDX_SCREEN_Y = 3;
    localparam int IDX_PRIMARY_LOW = 4;
    localparam int IDX_PRIMARY_HIGH_CTRL = 5;
    localparam int IDX_SECONDARY_LOW = 6;
    localparam int IDX_SECONDARY_HIGH_CTRL = 7;
    localparam int IDX_AUX_LOW = 8;
    localparam int IDX_AUX_HIGH_CTRL = 9;
    localparam int ENABLE_BIT = 15;
    localparam int PITCH_BIT = 14;
    localparam int EXCHANGE_BIT = 15;
    localparam int THREE_COLOR_BIT = 15;
    localparam int ORIGIN_COL_LSB = 0;
    localparam int ORIGIN_ROW_LSB = 8;
    localparam int ORIGIN_W = 6;
    localparam int POS_W = 11;
    localparam int BASE_NARROW_LSB = 4;
    localparam int BASE_WIDE_LO_W = 5;
    localparam int BASE_WIDE_HI_LSB = 11;
    localparam int ADDR_W = 22;
    localparam int NARROW_BASE_SHIFT = 10;
    localparam int WIDE_LO_SHIFT = 6;
    localparam int WIDE_HI_SHIFT = 17;
    localparam int PITCH_NARROW_SHIFT = 4;
    localparam int PITCH_WIDE_SHIFT = 11;
    localparam int PATTERN_SIZE = 64;
    localparam int WORDS_PER_ROW = 4;
    localparam logic [1:0] LAST_WORD = 2'h3;
    localparam logic [1:0] CODE_PRIMARY = 2'h0;
    localparam logic [1:0] CODE_SECONDARY = 2'h1;
    localparam logic [1:0] CODE_TRANSPARENT = 2'h2;
    localparam logic [1:0] CODE_INVERT_AUX = 2'h3;
    localparam logic [1:0] DEPTH_8 = 2'h0;
    localparam logic [1:0] DEPTH_16 = 2'h1;
    localparam logic [1:0] DEPTH_24 = 2'h2;
endpackage

// ===== logic/hco_pixel_mux.sv
// Holds the pattern code decoder that picks the cursor pixel colour.
// Assumes colours arrive already assembled to 24 bits; purely combinational.
`timescale 1ns/100ps
module hco_pixel_mux (
    // Pattern code and modes
    input wire logic [1:0] code,
    input wire logic exchange,
    input wire logic threeColor,
    input wire logic [1:0] colorMode,
    // Colours
    input wire logic [23:0] primary,
    input wire logic [23:0] secondary,
    input wire logic [23:0] auxColor,
    input wire logic [23:0] pixIn,
    // Result
    output logic [23:0] pixColor
);
    logic [23:0] depthMask;
    logic [23:0] firstColor;
    logic [23:0] secondColor;
    logic [23:0] thirdColor;
    logic [23:0] rawColor;

    assign depthMask = (colorMode == hco_pkg::DEPTH_8) ? 24'h0000FF :
                       (colorMode == hco_pkg::DEPTH_16) ? 24'h00FFFF : 24'hFFFFFF;
    assign firstColor = exchange ? secondary : primary;
    assign secondColor = exchange ? primary : secondary;
    assign thirdColor = threeColor ? auxColor : ~pixIn;

    always_comb begin
        case (code)
            hco_pkg::CODE_PRIMARY: rawColor = firstColor;
            hco_pkg::CODE_SECONDARY: rawColor = secondColor;
            hco_pkg::CODE_TRANSPARENT: rawColor = pixIn;
            hco_pkg::CODE_INVERT_AUX: rawColor = thirdColor;
            default: rawColor = pixIn;
        endcase
    end

    assign pixColor = (code == hco_pkg::CODE_TRANSPARENT) ? pixIn : (rawColor & depthMask);
endmodule // hco_pixel_mux

// ===== logic/hco_cursor_overlay.sv
// Holds the cursor overlay: register file, pattern row fetch and pixel overlay.
// Assumes display timing, pixel stream and memory port share clk; inputs are synchronous.
`timescale 1ns/100ps
module hco_cursor_overlay (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic regWr,
    input wire logic [15:0] regWrData,
    output logic [15:0] regRdData,
    // Display timing
    input wire logic lineStart,
    input wire logic [10:0] lineY,
    input wire logic [1:0] colorMode,
    // Pixel stream
    input wire logic pixValid,
    input wire logic [10:0] pixX,
    input wire logic [23:0] pixIn,
    output logic pixOutValid,
    output logic [23:0] pixOut,
    output logic cursorHit,
    // Pattern memory read port
    output logic memReq,
    output logic [21:0] memAddr,
    input wire logic memAck,
    input wire logic [31:0] memData
);
    typedef enum logic {FETCH_IDLE, FETCH_BUSY} hco_fetch_type;

    // Register file
    logic [15:0] regs_ff [hco_pkg::REG_COUNT];
    logic [15:0] nxt_regRdData;
    logic [15:0] regRdData_ff;

    // Decoded fields
    logic cursorEnable;
    logic pitchWide;
    logic exchange;
    logic threeColor;
    logic [5:0] originCol;
    logic [5:0] originRow;
    logic [10:0] screenX;
    logic [10:0] screenY;
    logic [23:0] primaryColor;
    logic [23:0] secondaryColor;
    logic [23:0] auxColor;

    // Row fetch
    hco_fetch_type state_ff;
    hco_fetch_type nxt_state;
    logic [1:0] wordIdx_ff;
    logic [1:0] nxt_wordIdx;
    logic memReq_ff;
    logic nxt_memReq;
    logic [21:0] memAddr_ff;
    logic [21:0] nxt_memAddr;
    logic rowHit_ff;
    logic nxt_rowHit;
    logic [31:0] rowBuf_ff [hco_pkg::WORDS_PER_ROW];
    logic [12:0] topEdge;
    logic [12:0] rowRel;
    logic rowInRange;
    logic [21:0] patternBase;
    logic [21:0] rowOffset;
    logic [21:0] rowStart;
    logic startFetch;
    logic wordDone;
    logic lastWord;

    // Pixel overlay
    logic [12:0] leftEdge;
    logic [12:0] colRel;
    logic colInRange;
    logic [127:0] rowBits;
    logic [1:0] pixCode;
    logic [23:0] cursorColor;
    logic overlayHere;
    logic [23:0] nxt_pixOut;
    logic [23:0] pixOut_ff;
    logic pixOutValid_ff;
    logic cursorHit_ff;

    // Register writes; reserved bits are never stored
    genvar gi;
    generate
        for (gi = 0; gi < hco_pkg::REG_COUNT; gi++) begin : g_reg
            logic regSel;
            assign regSel = regWr && (regAddr == hco_pkg::REG_OFS[gi]);
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    regs_ff[gi] <= hco_pkg::REG_RESET;
                end else if (regSel) begin
                    regs_ff[gi] <= regWrData & hco_pkg::REG_MASK[gi];
                end
            end
        end
    endgenerate

    // Register read, one cycle after the address
    always_comb begin
        nxt_regRdData = 16'h0000;
        for (int i = 0; i < hco_pkg::REG_COUNT; i++) begin
            if (regAddr == hco_pkg::REG_OFS[i]) begin
                nxt_regRdData = regs_ff[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            regRdData_ff <= 16'h0000;
        end else begin
            regRdData_ff <= nxt_regRdData;
        end
    end

    // Field decode
    assign cursorEnable = regs_ff[hco_pkg::IDX_PRIMARY_HIGH_CTRL][hco_pkg::ENABLE_BIT];
    assign pitchWide = regs_ff[hco_pkg::IDX_PRIMARY_HIGH_CTRL][hco_pkg::PITCH_BIT];
    assign exchange = regs_ff[hco_pkg::IDX_SECONDARY_HIGH_CTRL][hco_pkg::EXCHANGE_BIT];
    assign threeColor = regs_ff[hco_pkg::IDX_AUX_HIGH_CTRL][hco_pkg::THREE_COLOR_BIT];
    assign originCol = regs_ff[hco_pkg::IDX_ORIGIN][hco_pkg::ORIGIN_COL_LSB +: hco_pkg::ORIGIN_W];
    assign originRow = regs_ff[hco_pkg::IDX_ORIGIN][hco_pkg::ORIGIN_ROW_LSB +: hco_pkg::ORIGIN_W];
    assign screenX = regs_ff[hco_pkg::IDX_SCREEN_X][hco_pkg::POS_W-1:0];
    assign screenY = regs_ff[hco_pkg::IDX_SCREEN_Y][hco_pkg::POS_W-1:0];
    assign primaryColor = {regs_ff[hco_pkg::IDX_PRIMARY_HIGH_CTRL][7:0], regs_ff[hco_pkg::IDX_PRIMARY_LOW]};
    assign secondaryColor = {regs_ff[hco_pkg::IDX_SECONDARY_HIGH_CTRL][7:0],
        regs_ff[hco_pkg::IDX_SECONDARY_LOW]};
    assign auxColor = {regs_ff[hco_pkg::IDX_AUX_HIGH_CTRL][7:0], regs_ff[hco_pkg::IDX_AUX_LOW]};

    // Pattern base address by pitch
    assign patternBase = pitchWide ?
        ((22'(regs_ff[hco_pkg::IDX_PATTERN_BASE][hco_pkg::BASE_WIDE_HI_LSB +: 5]) << hco_pkg::WIDE_HI_SHIFT) |
         (22'(regs_ff[hco_pkg::IDX_PATTERN_BASE][hco_pkg::BASE_WIDE_LO_W-1:0]) << hco_pkg::WIDE_LO_SHIFT)) :
        (22'(regs_ff[hco_pkg::IDX_PATTERN_BASE][15:hco_pkg::BASE_NARROW_LSB]) << hco_pkg::NARROW_BASE_SHIFT);

    // Pattern row that falls on the coming line
    assign topEdge = {2'b00, screenY} - {7'b0000000, originRow};
    assign rowRel = {2'b00, lineY} - topEdge;
    assign rowInRange = !rowRel[12] && (rowRel[11:6] == 6'h00);
    assign rowOffset = pitchWide ? (22'(rowRel[5:0]) << hco_pkg::PITCH_WIDE_SHIFT) :
                                   (22'(rowRel[5:0]) << hco_pkg::PITCH_NARROW_SHIFT);
    assign rowStart = patternBase + rowOffset;

    assign startFetch = lineStart && cursorEnable && rowInRange;
    assign wordDone = (state_ff == FETCH_BUSY) && memAck;
    assign lastWord = wordIdx_ff == hco_pkg::LAST_WORD;

    // Fetch sequencing; a new line start drops any fetch in progress and fetches the new row only if enabled and in range
    always_comb begin
        nxt_state = state_ff;
        nxt_wordIdx = wordIdx_ff;
        nxt_memReq = memReq_ff;
        nxt_memAddr = memAddr_ff;
        nxt_rowHit = rowHit_ff;
        if (lineStart) begin
            nxt_rowHit = 1'b0;
            nxt_wordIdx = 2'h0;
            nxt_memAddr = rowStart;
            nxt_memReq = startFetch;
            nxt_state = startFetch ? FETCH_BUSY : FETCH_IDLE;
        end else begin
            case (state_ff)
                FETCH_IDLE: begin
                    nxt_memReq = 1'b0;
                end
                FETCH_BUSY: begin
                    if (memAck) begin
                        if (lastWord) begin
                            nxt_memReq = 1'b0;
                            nxt_rowHit = 1'b1;
                            nxt_state = FETCH_IDLE;
                        end else begin
                            nxt_wordIdx = wordIdx_ff + 2'h1;
                            nxt_memAddr = memAddr_ff + 22'h000004;
                        end
                    end
                end
                default: begin
                    nxt_memReq = 1'b0;
                    nxt_state = FETCH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= FETCH_IDLE;
            wordIdx_ff <= 2'h0;
            memReq_ff <= 1'b0;
            memAddr_ff <= 22'h000000;
            rowHit_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            wordIdx_ff <= nxt_wordIdx;
            memReq_ff <= nxt_memReq;
            memAddr_ff <= nxt_memAddr;
            rowHit_ff <= nxt_rowHit;
        end
    end

    // Row buffer, one word per entry
    generate
        for (gi = 0; gi < hco_pkg::WORDS_PER_ROW; gi++) begin : g_row
            logic wordSel;
            assign wordSel = wordDone && (wordIdx_ff == 2'(gi));
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    rowBuf_ff[gi] <= 32'h00000000;
                end else if (wordSel) begin
                    rowBuf_ff[gi] <= memData;
                end
            end
            assign rowBits[gi*32 +: 32] = rowBuf_ff[gi];
        end
    endgenerate

    // Pattern column under the current pixel
    assign leftEdge = {2'b00, screenX} - {7'b0000000, originCol};
    assign colRel = {2'b00, pixX} - leftEdge;
    assign colInRange = !colRel[12] && (colRel[11:6] == 6'h00);
    assign pixCode = rowBits[{colRel[5:0], 1'b0} +: 2];
    assign overlayHere = cursorEnable && rowHit_ff && colInRange;

    hco_pixel_mux u_pixel_mux (
        .code(pixCode),
        .exchange(exchange),
        .threeColor(threeColor),
        .colorMode(colorMode),
        .primary(primaryColor),
        .secondary(secondaryColor),
        .auxColor(auxColor),
        .pixIn(pixIn),
        .pixColor(cursorColor)
    );

    assign nxt_pixOut = overlayHere ? cursorColor : pixIn;

    // Output pixel stage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pixOut_ff <= 24'h000000;
            pixOutValid_ff <= 1'b0;
            cursorHit_ff <= 1'b0;
        end else begin
            pixOut_ff <= nxt_pixOut;
            pixOutValid_ff <= pixValid;
            cursorHit_ff <= pixValid && overlayHere;
        end
    end

    assign regRdData = regRdData_ff;
    assign pixOut = pixOut_ff;
    assign pixOutValid = pixOutValid_ff;
    assign cursorHit = cursorHit_ff;
    assign memReq = memReq_ff;
    assign memAddr = memAddr_ff;
endmodule // hco_cursor_overlay

// ===== testbench/hco_overlay_props.sv
// Checker of the cursor overlay ports: fetch handshake, pixel path, register reads.
// Assumes one clock, clk, with rstn as its asynchronous active-low reset.
`timescale 1ns/100ps
module hco_overlay_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic regWr,
    input wire logic [15:0] regWrData,
    input wire logic [15:0] regRdData,
    // Display and pixels
    input wire logic lineStart,
    input wire logic pixValid,
    input wire logic [23:0] pixIn,
    input wire logic pixOutValid,
    input wire logic [23:0] pixOut,
    input wire logic cursorHit,
    // Memory port
    input wire logic memReq,
    input wire logic [21:0] memAddr,
    input wire logic memAck
);
    logic cursorEn_ff;
    wire logic regMapped;
    assign regMapped = regAddr >= 8'h84 && regAddr <= 8'hA8 && regAddr[1:0] == 2'h0;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cursorEn_ff <= 1'b0;
        end else if (regWr && regAddr == 8'h98) begin
            cursorEn_ff <= regWrData[15];
        end
    end
    a_req_holds: assert property (memReq && !memAck && !lineStart |=> memReq && $stable(memAddr))
        else $error("memory request dropped or moved before acknowledge");
    a_addr_step: assert property (memReq && memAck && !lineStart |=> !memReq || memAddr == $past(memAddr) + 22'h4)
        else $error("next pattern word address is not four bytes on");
    a_req_cause: assert property ($rose(memReq) |-> $past(lineStart))
        else $error("pattern fetch started without a line start");
    a_off_nofetch: assert property (lineStart && !cursorEn_ff |=> !memReq)
        else $error("pattern fetched while cursor disabled");
    a_hit_enabled: assert property (cursorHit |-> $past(cursorEn_ff))
        else $error("cursor pixel shown while cursor disabled");
    a_miss_passes: assert property (pixOutValid && !cursorHit |-> pixOut == $past(pixIn))
        else $error("pixel outside cursor was altered");
    a_valid_lag: assert property (1'b1 |-> pixOutValid == $past(pixValid))
        else $error("output pixel valid does not follow input by one cycle");
    a_unmapped_zero: assert property (!$past(regMapped) |-> regRdData == 16'h0000)
        else $error("unmapped register read is not zero");
    a_origin_resv: assert property ($past(regAddr) == 8'h88 |-> regRdData[7:6] == 2'h0 && regRdData[15:14] == 2'h0)
        else $error("reserved origin bits read nonzero");
    a_pos_resv: assert property ($past(regAddr) inside {8'h8C, 8'h90} |-> regRdData[15:11] == 5'h00)
        else $error("reserved position bits read nonzero");
endmodule // hco_overlay_props

// ===== testbench/tb.sv
// Testbench of the cursor overlay: registers, pattern row fetch and pixel colours.
// Assumes the design alone on a 20 MHz clock; inputs change 5 ns after rising edges.
`timescale 1ns/100ps
module tb;
    logic clk, rstn, regWr, lineStart, pixValid, memAck, pixOutValid, cursorHit, memReq;
    logic [7:0] regAddr;
    logic [15:0] regWrData, regRdData;
    logic [10:0] lineY, pixX;
    logic [1:0] colorMode;
    logic [23:0] pixIn, pixOut;
    logic [21:0] memAddr;
    logic [31:0] memData;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    hco_cursor_overlay u_dut (.clk, .rstn, .regAddr, .regWr, .regWrData, .regRdData, .lineStart, .lineY,
        .colorMode, .pixValid, .pixX, .pixIn, .pixOutValid, .pixOut, .cursorHit, .memReq, .memAddr, .memAck,
        .memData);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic tick();
        @(posedge clk);
        #5;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        regAddr = a;
        regWrData = d;
        regWr = 1'b1;
        tick();
        regWr = 1'b0;
        tick();
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        regAddr = a;
        tick();
        check(regRdData, exp, "register read");
    endtask
    task automatic fetch(input logic [10:0] y, input logic [21:0] a);
        lineY = y;
        lineStart = 1'b1;
        tick();
        lineStart = 1'b0;
        for (int k = 0; k < 4; k++) begin
            if (k > 0) tick();
            check(memReq, 1'b1, "fetch request");
            check(memAddr, a + 22'(4 * k), "fetch address");
            memData = 32'hE4E4E4E4;
            memAck = 1'b1;
            tick();
            memAck = 1'b0;
            memData = 32'h1B1B1B1B;
        end
        tick();
        check(memReq, 1'b0, "fetch end");
    endtask
    task automatic noFetch(input logic [10:0] y);
        lineY = y;
        lineStart = 1'b1;
        tick();
        lineStart = 1'b0;
        repeat (3) begin
            check(memReq, 1'b0, "no fetch");
            tick();
        end
    endtask
    task automatic pix(input logic [10:0] x, input logic [23:0] in, input logic [23:0] exp, input logic hit);
        pixValid = 1'b1;
        pixX = x;
        pixIn = in;
        tick();
        check(pixOutValid, 1'b1, "pixel valid");
        check(pixOut, exp, "pixel colour");
        check(cursorHit, hit, "cursor hit");
        pixValid = 1'b0;
        tick();
    endtask
    task automatic test_regs();
        for (int i = 0; i < hco_pkg::REG_COUNT; i++) rd(hco_pkg::REG_OFS[i], 16'h0000);
        for (int i = 0; i < hco_pkg::REG_COUNT; i++) begin
            wr(hco_pkg::REG_OFS[i], 16'hFFFF);
            rd(hco_pkg::REG_OFS[i], hco_pkg::REG_MASK[i]);
            wr(hco_pkg::REG_OFS[i], 16'h0000);
        end
        wr(8'h80, 16'hFFFF);
        rd(8'h80, 16'h0000);
        rd(8'hB0, 16'h0000);
        $display("test_regs done");
    endtask
    task automatic test_narrow();
        wr(8'h84, 16'h0230);
        wr(8'h88, 16'h0302);
        wr(8'h8C, 16'h0064);
        wr(8'h90, 16'h0032);
        wr(8'h94, 16'h1234);
        wr(8'h98, 16'h80AB);
        wr(8'h9C, 16'h5678);
        wr(8'hA4, 16'h9ABC);
        wr(8'hA8, 16'h00CD);
        colorMode = 2'h1;
        fetch(11'd52, 22'h008C50);
        pix(11'd98, 24'hF0F0F0, 24'h001234, 1'b1);
        pix(11'd99, 24'hF0F0F0, 24'h005678, 1'b1);
        pix(11'd100, 24'hF0F0F0, 24'hF0F0F0, 1'b1);
        pix(11'd101, 24'hF0F0F0, 24'h000F0F, 1'b1);
        pix(11'd97, 24'hF0F0F0, 24'hF0F0F0, 1'b0);
        pix(11'd161, 24'hF0F0F0, 24'h000F0F, 1'b1);
        pix(11'd162, 24'hF0F0F0, 24'hF0F0F0, 1'b0);
        colorMode = 2'h0;
        pix(11'd98, 24'hF0F0F0, 24'h000034, 1'b1);
        colorMode = 2'h2;
        pix(11'd98, 24'hF0F0F0, 24'hAB1234, 1'b1);
        pix(11'd99, 24'hF0F0F0, 24'h005678, 1'b1);
        $display("test_narrow done");
    endtask
    task automatic test_swap();
        wr(8'hA0, 16'h80EF);
        wr(8'hA8, 16'h80CD);
        fetch(11'd47, 22'h008C00);
        pix(11'd98, 24'hF0F0F0, 24'hEF5678, 1'b1);
        pix(11'd99, 24'hF0F0F0, 24'hAB1234, 1'b1);
        pix(11'd101, 24'hF0F0F0, 24'hCD9ABC, 1'b1);
        colorMode = 2'h3;
        pix(11'd101, 24'hF0F0F0, 24'hCD9ABC, 1'b1);
        $display("test_swap done");
    endtask
    task automatic test_wide();
        wr(8'h84, 16'hF81F);
        wr(8'h98, 16'hC0AB);
        fetch(11'd110, 22'h3FFFC0);
        noFetch(11'd46);
        noFetch(11'd111);
        $display("test_wide done");
    endtask
    task automatic test_disable();
        fetch(11'd110, 22'h3FFFC0);
        pix(11'd98, 24'h0F0F0F, 24'hEF5678, 1'b1);
        wr(8'h98, 16'h00AB);
        pix(11'd98, 24'h0F0F0F, 24'h0F0F0F, 1'b0);
        noFetch(11'd52);
        $display("test_disable done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            $display("[FAIL] %0t run did not finish in time", $time);
            results();
        end
    end
    initial begin
        {rstn, regWr, lineStart, pixValid, memAck} = 5'h00;
        regAddr = 8'h00;
        regWrData = 16'h0000;
        {lineY, pixX} = 22'h000000;
        colorMode = 2'h0;
        pixIn = 24'h000000;
        memData = 32'h00000000;
        repeat (4) @(posedge clk);
        #5;
        rstn = 1'b1;
        test_regs();
        test_narrow();
        test_swap();
        test_wide();
        test_disable();
        results();
    end
endmodule // tb
bind hco_cursor_overlay hco_overlay_props u_props (.clk, .rstn, .regAddr, .regWr, .regWrData, .regRdData,
    .lineStart, .pixValid, .pixIn, .pixOutValid, .pixOut, .cursorHit, .memReq, .memAddr, .memAck);
